/* File: inc/talm_consts.svh */
/*
 Timing counts, thresholds and patterns of the T1 alarm monitor.
 Assumes inclusion by bare name from the monitor design file.
*/
`ifndef TALM_CONSTS_SVH
`define TALM_CONSTS_SVH
`define TALM_AIS_FRAMES_SF    5'h0C
`define TALM_AIS_FRAMES_ESF   5'h18
`define TALM_AIS_SET_LT       4'h3
`define TALM_AIS_SET_LT_S_SF  4'h4
`define TALM_AIS_SET_LT_S_ESF 4'h6
`define TALM_AIS_REL_GT       4'h2
`define TALM_AIS_REL_GT_S_SF  4'h3
`define TALM_AIS_REL_GT_S_ESF 4'h5
`define TALM_RA_B2_RUN        8'hFF
`define TALM_RA_MISS          2'h3
`define TALM_RA_DL_PATTERN    16'hFF00
`define TALM_RA_DL_GAP        4'hF
`define TALM_EXZ_B8ZS         13'h0007
`define TALM_EXZ_AMI          13'h000F
`define TALM_PD_RUN           13'h000F
`define TALM_PD_N_MAX         23
`define TALM_LOS_ALT_RUN      13'h000F
`define TALM_TX_SHORT_PER     3'h3
`define TALM_TX_ZERO_RUN      6'h20
`endif

/* File: inc/talm_pkg.sv */
/*
 Types of the T1 alarm monitor.
 Assumes talm_consts.svh on the include path.
*/
`default_nettype none
package talm_pkg;
  typedef enum logic [0:0] {TALM_AMI = 1'b0, TALM_B8ZS = 1'b1} talm_code_t;
  typedef enum logic [0:0] {TALM_D4 = 1'b0, TALM_ESF = 1'b1} talm_fmt_t;
  typedef enum logic [0:0] {TALM_LOS_IDLE = 1'b0, TALM_LOS_LOST = 1'b1} talm_los_t;
endpackage
`default_nettype wire

/* File: hdl/talm_run_counter.sv */
/*
 Saturating run counter: counts consecutive qualifying steps.
 Assumes step and zero are synchronous to clk_sys.
*/
`default_nettype none
module talm_run_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Step and qualifier
  input  wire logic             step,
  input  wire logic             zero,
  // Run length
  output logic [WIDTH-1:0]      count
);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (step) begin
      if (!zero) begin
        count <= '0;
      end else if (count != {WIDTH{1'b1}}) begin
        count <= count + WIDTH'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/talm_monitor.sv */
/*
 T1 receive and transmit alarm monitor: signal loss, blue alarm,
 remote alarm, excess zeros, pulse density, transmit line checks.
 Assumes strobes from a framer, all synchronous to clk_sys.
*/
// Behaviour
// - Lose signal after programmable zero run
// - Recover on enough ones within window
// - Or recover: density fine, no long run
// - Blue alarm: fewer than 3 zeros
// - Strict blue alarm: fewer than 4/6 zeros
// - Blue release: more than 2 zeros
// - Strict blue release: more than 3/5 zeros
// - Blue alarm held until a multiframe starts
// - Mode 0: bit 2 zero, 255 slots
// - Frame-12 FS one or DL pattern
// - Mode 1: bit 2 zero whole frame
// - Mode 0: release when conditions gone
// - Mode 1: release after 3 misses
// - Excess zeros: over 7 or 15
// - Density violation over all windows
// - Zero and density flags clear on read
// - Line short after 4 overcurrent periods
// - Ones missing after 32 transmit zeros
// - Blue and loss status plus irq
// - Remote status, onset and release irqs
// - Shared transmit line change irq
// - Send alarms only while enabled
`default_nettype none
`include "talm_consts.svh"
module talm_monitor
  import talm_pkg::*;
#(
  parameter int PD_N_MAX = `TALM_PD_N_MAX
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Receive stream
  input  wire logic        rx_bit_en,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit2_valid,
  input  wire logic        rx_fs12_valid,
  input  wire logic        rx_dl_valid,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_mf_start,
  // Transmit stream
  input  wire logic        tx_bit_en,
  input  wire logic        tx_bit,
  input  wire logic        tx_overcurrent,
  // Configuration
  input  wire talm_fmt_t   frame_fmt,
  input  wire talm_code_t  line_code,
  input  wire logic        strict_blue_alarm_sel,
  input  wire logic        remote_alarm_mode_sel,
  input  wire logic [12:0] los_detect_periods,
  input  wire logic [8:0]  los_recover_ones,
  input  wire logic [12:0] los_recover_window,
  input  wire logic        send_blue_alarm_en,
  input  wire logic        send_remote_alarm_en,
  // Software acknowledges
  input  wire logic        excess_zeros_read,
  input  wire logic        density_violation_read,
  input  wire logic        blue_alarm_irq_clr,
  input  wire logic        signal_lost_irq_clr,
  input  wire logic        remote_alarm_onset_irq_clr,
  input  wire logic        remote_alarm_release_irq_clr,
  input  wire logic        density_violation_irq_clr,
  input  wire logic        tx_line_change_irq_clr,
  // Status
  output logic             signal_lost_status,
  output logic             blue_alarm_status,
  output logic             remote_alarm_status,
  output logic             excess_zeros_status,
  output logic             density_violation_status,
  output logic             tx_line_short_status,
  output logic             tx_ones_missing_status,
  // Interrupt status
  output logic             signal_lost_irq,
  output logic             blue_alarm_irq,
  output logic             remote_alarm_onset_irq,
  output logic             remote_alarm_release_irq,
  output logic             density_violation_irq,
  output logic             tx_line_change_irq,
  // Transmit alarm requests
  output logic             blue_alarm_send,
  output logic             remote_alarm_send
);
  localparam int HIST = (PD_N_MAX + 1) * 8;

  logic [12:0] rx_zero_run;
  logic [7:0]  b2_run;
  logic [5:0]  tx_zero_run;
  logic [2:0]  oc_run;

  talm_run_counter #(.WIDTH(13)) u_rx_run (
    .clk_sys (clk_sys),
    .reset   (reset),
    .step    (rx_bit_en),
    .zero    (!rx_bit),
    .count   (rx_zero_run)
  );
  talm_run_counter #(.WIDTH(8)) u_b2_run (
    .clk_sys (clk_sys),
    .reset   (reset),
    .step    (rx_bit2_valid),
    .zero    (!rx_bit),
    .count   (b2_run)
  );
  talm_run_counter #(.WIDTH(6)) u_tx_run (
    .clk_sys (clk_sys),
    .reset   (reset),
    .step    (tx_bit_en),
    .zero    (!tx_bit),
    .count   (tx_zero_run)
  );
  talm_run_counter #(.WIDTH(3)) u_oc_run (
    .clk_sys (clk_sys),
    .reset   (reset),
    .step    (tx_bit_en),
    .zero    (tx_overcurrent),
    .count   (oc_run)
  );

  // Pulse density: one running ones count per window length
  logic [HIST-1:0]     pd_hist;
  logic [7:0]          pd_fill;
  logic [PD_N_MAX:1]   pd_win_fault;
  logic                pd_hit;
  logic                pd_level;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pd_hist <= '0;
      pd_fill <= '0;
    end else if (rx_bit_en) begin
      pd_hist <= {pd_hist[HIST-2:0], rx_bit};
      if (pd_fill != 8'(HIST)) begin
        pd_fill <= pd_fill + 8'h01;
      end
    end
  end

  for (genvar n = 1; n <= PD_N_MAX; n++) begin : g_pd
    localparam int LEN = 8 * (n + 1);
    logic [7:0] ones;
    logic       drop;
    assign drop = (pd_fill >= 8'(LEN)) && pd_hist[LEN-1];
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        ones <= '0;
      end else if (rx_bit_en) begin
        ones <= ones + {7'h00, rx_bit} - {7'h00, drop};
      end
    end
    // Windows not yet filled cannot be judged
    assign pd_win_fault[n] = (pd_fill >= 8'(LEN)) && (ones < 8'(n));
  end

  assign pd_hit = (|pd_win_fault) || (rx_zero_run > `TALM_PD_RUN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pd_level <= 1'b0;
    end else begin
      pd_level <= pd_hit;
    end
  end

  // Latched receive flags, a new hit beats the read
  logic exz_hit;
  assign exz_hit = rx_zero_run > ((line_code == TALM_B8ZS) ? `TALM_EXZ_B8ZS : `TALM_EXZ_AMI);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      excess_zeros_status      <= 1'b0;
      density_violation_status <= 1'b0;
    end else begin
      excess_zeros_status      <= (excess_zeros_status && !excess_zeros_read) || exz_hit;
      density_violation_status <= (density_violation_status && !density_violation_read) || pd_hit;
    end
  end

  // Signal loss and recovery
  talm_los_t   los_state;
  logic [12:0] los_win;
  logic [8:0]  los_ones;
  logic [8:0]  next_los_ones;
  logic        los_long_run;
  logic        los_pd_seen;
  logic        los_win_end;
  logic        los_alt_ok;

  assign next_los_ones = los_ones + {8'h00, rx_bit};
  assign los_win_end   = (los_win + 13'h0001) >= los_recover_window;
  assign los_alt_ok    = !los_long_run && !los_pd_seen && !pd_hit
                         && !(!rx_bit && rx_zero_run >= `TALM_LOS_ALT_RUN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      los_state    <= TALM_LOS_IDLE;
      los_win      <= '0;
      los_ones     <= '0;
      los_long_run <= 1'b0;
      los_pd_seen  <= 1'b0;
    end else begin
      unique case (los_state)
        TALM_LOS_IDLE: begin
          los_win      <= '0;
          los_ones     <= '0;
          los_long_run <= 1'b0;
          los_pd_seen  <= 1'b0;
          if (rx_zero_run >= los_detect_periods) begin
            los_state <= TALM_LOS_LOST;
          end
        end
        TALM_LOS_LOST: begin
          if (rx_bit_en) begin
            if (next_los_ones >= los_recover_ones) begin
              los_state <= TALM_LOS_IDLE;
            end else if (los_win_end && los_alt_ok) begin
              los_state <= TALM_LOS_IDLE;
            end
            if (los_win_end) begin
              los_win      <= '0;
              los_ones     <= '0;
              los_long_run <= 1'b0;
              los_pd_seen  <= 1'b0;
            end else begin
              los_win      <= los_win + 13'h0001;
              los_ones     <= next_los_ones;
              los_long_run <= los_long_run || (!rx_bit && rx_zero_run >= `TALM_LOS_ALT_RUN);
              los_pd_seen  <= los_pd_seen || pd_hit;
            end
          end
        end
      endcase
    end
  end

  // Blue alarm: zeros counted over 12 or 24 frames
  logic [4:0] ais_frames;
  logic [4:0] ais_frame_cnt;
  logic [3:0] ais_zeros;
  logic [3:0] next_ais_zeros;
  logic [3:0] ais_set_lt;
  logic [3:0] ais_rel_gt;
  logic       ais_held;
  logic       ais_win_end;
  logic       next_blue;

  assign ais_frames = (frame_fmt == TALM_ESF) ? `TALM_AIS_FRAMES_ESF : `TALM_AIS_FRAMES_SF;
  assign ais_set_lt = !strict_blue_alarm_sel ? `TALM_AIS_SET_LT
                    : (frame_fmt == TALM_ESF) ? `TALM_AIS_SET_LT_S_ESF : `TALM_AIS_SET_LT_S_SF;
  assign ais_rel_gt = !strict_blue_alarm_sel ? `TALM_AIS_REL_GT
                    : (frame_fmt == TALM_ESF) ? `TALM_AIS_REL_GT_S_ESF : `TALM_AIS_REL_GT_S_SF;
  assign next_ais_zeros = (rx_bit_en && !rx_bit && ais_zeros != 4'hF) ? ais_zeros + 4'h1 : ais_zeros;
  assign ais_win_end = rx_frame_end && (ais_frame_cnt + 5'h01 >= ais_frames);

  always_comb begin
    next_blue = blue_alarm_status;
    if (ais_win_end) begin
      if (!blue_alarm_status && next_ais_zeros < ais_set_lt) begin
        next_blue = 1'b1;
      end else if (blue_alarm_status && ais_held && next_ais_zeros > ais_rel_gt) begin
        next_blue = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ais_frame_cnt     <= '0;
      ais_zeros         <= '0;
      ais_held          <= 1'b0;
      blue_alarm_status <= 1'b0;
    end else begin
      blue_alarm_status <= next_blue;
      ais_zeros         <= ais_win_end ? 4'h0 : next_ais_zeros;
      if (rx_frame_end) begin
        ais_frame_cnt <= ais_win_end ? 5'h00 : ais_frame_cnt + 5'h01;
      end
      // A multiframe must start after onset before release
      if (next_blue && !blue_alarm_status) begin
        ais_held <= 1'b0;
      end else if (rx_mf_start) begin
        ais_held <= 1'b1;
      end
    end
  end

  // Remote alarm sources
  logic        b2_all_zero;
  logic [15:0] dl_shift;
  logic [15:0] next_dl_shift;
  logic [3:0]  dl_gap;
  logic        b2_hit;
  logic        fs_hit;
  logic        fs_miss;
  logic        dl_hit;
  logic        dl_miss;
  logic        ra_fs_cond;
  logic        ra_dl_cond;
  logic        ra_b2_cond;
  logic [1:0]  miss_b2;
  logic [1:0]  miss_fs;
  logic [1:0]  miss_dl;
  logic        ra_set;
  logic        ra_rel;
  logic        next_remote;

  assign next_dl_shift = {dl_shift[14:0], rx_bit};
  assign b2_hit  = rx_frame_end && b2_all_zero;
  assign fs_hit  = rx_fs12_valid && rx_bit && (frame_fmt == TALM_D4);
  assign fs_miss = rx_fs12_valid && !rx_bit && (frame_fmt == TALM_D4);
  assign dl_hit  = rx_dl_valid && (frame_fmt == TALM_ESF)
                   && (next_dl_shift == `TALM_RA_DL_PATTERN);
  assign dl_miss = rx_dl_valid && (frame_fmt == TALM_ESF) && !dl_hit && (dl_gap == `TALM_RA_DL_GAP);
  assign ra_b2_cond = (b2_run == `TALM_RA_B2_RUN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      b2_all_zero <= 1'b1;
      dl_shift    <= '0;
      dl_gap      <= '0;
      ra_fs_cond  <= 1'b0;
      ra_dl_cond  <= 1'b0;
    end else begin
      if (rx_frame_end) begin
        b2_all_zero <= 1'b1;
      end else if (rx_bit2_valid && rx_bit) begin
        b2_all_zero <= 1'b0;
      end
      if (rx_dl_valid) begin
        dl_shift <= next_dl_shift;
        dl_gap   <= dl_hit ? 4'h0 : dl_gap + 4'h1;
      end
      if (fs_hit || fs_miss || frame_fmt != TALM_D4) begin
        ra_fs_cond <= fs_hit;
      end
      if (dl_hit || dl_miss || frame_fmt != TALM_ESF) begin
        ra_dl_cond <= dl_hit;
      end
    end
  end

  // Miss counters saturate at the release count
  function automatic logic [1:0] talm_miss(input logic [1:0] cnt, input logic hit, input logic miss);
    talm_miss = hit ? 2'h0 : (miss && cnt != `TALM_RA_MISS) ? cnt + 2'h1 : cnt;
  endfunction

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      miss_b2 <= '0;
      miss_fs <= '0;
      miss_dl <= '0;
    end else begin
      miss_b2 <= talm_miss(miss_b2, b2_hit, rx_frame_end && !b2_hit);
      miss_fs <= talm_miss(miss_fs, fs_hit, fs_miss);
      miss_dl <= talm_miss(miss_dl, dl_hit, dl_miss);
    end
  end

  always_comb begin
    if (remote_alarm_mode_sel) begin
      ra_set = b2_hit || fs_hit || dl_hit;
      ra_rel = (miss_b2 == `TALM_RA_MISS)
               && ((frame_fmt == TALM_ESF) ? miss_dl == `TALM_RA_MISS
                                           : miss_fs == `TALM_RA_MISS);
    end else begin
      ra_set = ra_b2_cond || ra_fs_cond || ra_dl_cond;
      ra_rel = !ra_set;
    end
    next_remote = ra_set ? 1'b1 : (ra_rel ? 1'b0 : remote_alarm_status);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      remote_alarm_status <= 1'b0;
    end else begin
      remote_alarm_status <= next_remote;
    end
  end

  // Transmit line supervision
  logic next_short;
  logic next_ones_missing;

  assign next_short = (oc_run > `TALM_TX_SHORT_PER) ? 1'b1
                    : (!tx_overcurrent ? 1'b0 : tx_line_short_status);
  assign next_ones_missing = (tx_zero_run >= `TALM_TX_ZERO_RUN);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_line_short_status   <= 1'b0;
      tx_ones_missing_status <= 1'b0;
    end else begin
      tx_line_short_status   <= next_short;
      tx_ones_missing_status <= next_ones_missing;
    end
  end

  // Signal loss status follows the loss state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      signal_lost_status <= 1'b0;
    end else begin
      signal_lost_status <= (los_state == TALM_LOS_LOST);
    end
  end

  // Sticky interrupt bits; a same-cycle event beats the clear
  logic ev_los;
  logic ev_blue;
  logic ev_ra_on;
  logic ev_ra_off;
  logic ev_pd;
  logic ev_tx;

  assign ev_los    = signal_lost_status != (los_state == TALM_LOS_LOST);
  assign ev_blue   = next_blue != blue_alarm_status;
  assign ev_ra_on  = next_remote && !remote_alarm_status;
  assign ev_ra_off = !next_remote && remote_alarm_status;
  assign ev_pd     = pd_hit && !pd_level;
  assign ev_tx     = (next_short != tx_line_short_status)
                     || (next_ones_missing != tx_ones_missing_status);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      signal_lost_irq          <= 1'b0;
      blue_alarm_irq           <= 1'b0;
      remote_alarm_onset_irq   <= 1'b0;
      remote_alarm_release_irq <= 1'b0;
      density_violation_irq    <= 1'b0;
      tx_line_change_irq       <= 1'b0;
    end else begin
      signal_lost_irq          <= (signal_lost_irq && !signal_lost_irq_clr) || ev_los;
      blue_alarm_irq           <= (blue_alarm_irq && !blue_alarm_irq_clr) || ev_blue;
      remote_alarm_onset_irq   <= (remote_alarm_onset_irq && !remote_alarm_onset_irq_clr) || ev_ra_on;
      remote_alarm_release_irq <= (remote_alarm_release_irq && !remote_alarm_release_irq_clr) || ev_ra_off;
      density_violation_irq    <= (density_violation_irq && !density_violation_irq_clr) || ev_pd;
      tx_line_change_irq       <= (tx_line_change_irq && !tx_line_change_irq_clr) || ev_tx;
    end
  end

  // Alarm transmission requests
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      blue_alarm_send   <= 1'b0;
      remote_alarm_send <= 1'b0;
    end else begin
      blue_alarm_send   <= send_blue_alarm_en;
      remote_alarm_send <= send_remote_alarm_en;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/talm_monitor_assertions.sv */
/*
 Port checks of the T1 alarm monitor.
 Assumes binding into talm_monitor; one clock domain.
*/
`default_nettype none
module talm_monitor_checker
  import talm_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Streams
  input wire logic       rx_bit_en,
  input wire logic       rx_bit,
  input wire logic       tx_bit_en,
  input wire logic       tx_bit,
  input wire logic       tx_overcurrent,
  input wire talm_code_t line_code,
  // Controls
  input wire logic       send_blue_alarm_en,
  input wire logic       send_remote_alarm_en,
  input wire logic       excess_zeros_read,
  input wire logic       density_violation_read,
  input wire logic       blue_alarm_irq_clr,
  // Flags
  input wire logic       signal_lost_status,
  input wire logic       blue_alarm_status,
  input wire logic       remote_alarm_status,
  input wire logic       excess_zeros_status,
  input wire logic       density_violation_status,
  input wire logic       tx_line_short_status,
  input wire logic       tx_ones_missing_status,
  input wire logic       signal_lost_irq,
  input wire logic       blue_alarm_irq,
  input wire logic       remote_alarm_onset_irq,
  input wire logic       remote_alarm_release_irq,
  input wire logic       tx_line_change_irq,
  input wire logic       blue_alarm_send,
  input wire logic       remote_alarm_send
);
  // Saturating runs, so long idles cannot wrap
  logic [5:0] tz;
  logic [4:0] rz;
  logic [2:0] oc;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {tz, rz, oc} <= '0;
    end else begin
      if (tx_bit_en) begin
        tz <= tx_bit ? '0 : tz + {5'h00, ~&tz};
        oc <= tx_overcurrent ? oc + {2'h0, ~&oc} : '0;
      end
      if (rx_bit_en) begin
        rz <= rx_bit ? '0 : rz + {4'h0, ~&rz};
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_send_blue: assert property (!$past(reset) |-> blue_alarm_send == $past(send_blue_alarm_en))
    else $error("blue send not following enable");
  chk_send_remote: assert property (!$past(reset) |-> remote_alarm_send == $past(send_remote_alarm_en))
    else $error("remote send not following enable");
  chk_ones_set: assert property (tx_bit_en && !tx_bit && tz == 6'h1F |-> ##2 tx_ones_missing_status)
    else $error("ones missing not flagged");
  chk_ones_clear: assert property (tx_bit_en && tx_bit |-> ##2 !tx_ones_missing_status)
    else $error("ones missing not cleared");
  chk_short_set: assert property (tx_bit_en && tx_overcurrent && oc == 3'h3 |-> ##[1:2] tx_line_short_status)
    else $error("line short not flagged");
  chk_zeros_set: assert property (rx_bit_en && !rx_bit && rz == (line_code == TALM_B8ZS ? 5'h07 : 5'h0F)
    |-> ##[1:2] excess_zeros_status) else $error("excess zeros not flagged");
  chk_line_irq: assert property ($changed(tx_line_short_status) || $changed(tx_ones_missing_status)
    |-> tx_line_change_irq) else $error("line change irq missing");
  chk_blue_irq: assert property ($changed(blue_alarm_status) |-> blue_alarm_irq)
    else $error("blue irq missing");
  chk_lost_irq: assert property ($changed(signal_lost_status) |-> signal_lost_irq)
    else $error("loss irq missing");
  chk_ra_onset: assert property ($rose(remote_alarm_status) |-> remote_alarm_onset_irq)
    else $error("remote onset irq missing");
  chk_ra_release: assert property ($fell(remote_alarm_status) |-> remote_alarm_release_irq)
    else $error("remote release irq missing");
  chk_zeros_latch: assert property ($fell(excess_zeros_status) |-> $past(excess_zeros_read))
    else $error("excess zeros dropped unread");
  chk_density_latch: assert property ($fell(density_violation_status) |-> $past(density_violation_read))
    else $error("density flag dropped unread");
  chk_irq_sticky: assert property ($fell(blue_alarm_irq) |-> $past(blue_alarm_irq_clr))
    else $error("blue irq dropped uncleared");
endmodule
bind talm_monitor talm_monitor_checker u_chk (.*);
`default_nettype wire

/* File: testbench/talm_line_model.sv */
/*
 Remote line terminal: drives the receive strobes.
 Assumes its tasks are called from the bench after reset.
*/
`default_nettype none
module talm_line_model (
  // Clock
  input  wire logic clk_sys,
  // Receive strobes
  output logic      rx_bit_en,
  output logic      rx_bit,
  output logic      rx_bit2_valid,
  output logic      rx_fs12_valid,
  output logic      rx_dl_valid,
  output logic      rx_frame_end,
  output logic      rx_mf_start
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rx_bit_en, rx_bit, rx_bit2_valid, rx_fs12_valid, rx_dl_valid, rx_frame_end, rx_mf_start} = '0;
  // Kind 0 payload, 1 bit 2, 2 frame-12 FS bit
  task automatic send(input int n, input logic v, input int k);
    repeat (n) begin
      @(posedge clk_sys) #1;
      {rx_bit_en, rx_bit} = {1'b1, v};
      rx_bit2_valid = (k == 1);
      rx_fs12_valid = (k == 2);
    end
    @(posedge clk_sys) #1;
    {rx_bit_en, rx_bit2_valid, rx_fs12_valid} = '0;
    // Idle line must not repeat the last bit
    rx_bit = ~v;
  endtask
  task automatic mark(input logic mf);
    @(posedge clk_sys) #1;
    {rx_frame_end, rx_mf_start} = {!mf, mf};
    @(posedge clk_sys) #1;
    {rx_frame_end, rx_mf_start} = '0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/talm_monitor_tb.sv */
/*
 Self-checking bench of the T1 alarm monitor.
 Assumes line model and checker compiled before it.
*/
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0b got %0b", nm, e, g); end end
module talm_monitor_tb
  import talm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = '0, reset = '1;
  logic        rx_bit_en, rx_bit, rx_bit2_valid, rx_fs12_valid, rx_dl_valid, rx_frame_end, rx_mf_start;
  logic        tx_bit_en = '0, tx_bit = '0, tx_overcurrent = '0, tx_line_change_irq_clr;
  talm_fmt_t   frame_fmt = TALM_D4;
  talm_code_t  line_code = TALM_AMI;
  logic        strict_blue_alarm_sel = '0, remote_alarm_mode_sel = '0;
  logic        send_blue_alarm_en = '0, send_remote_alarm_en = '0;
  logic [12:0] los_detect_periods = 13'h0010, los_recover_window = 13'h0010;
  logic [8:0]  los_recover_ones = 9'h004;
  logic [7:0]  ack = '0;
  logic        excess_zeros_read, density_violation_read, blue_alarm_irq_clr, signal_lost_irq_clr;
  logic        remote_alarm_onset_irq_clr, remote_alarm_release_irq_clr, density_violation_irq_clr;
  logic        signal_lost_status, blue_alarm_status, remote_alarm_status, excess_zeros_status;
  logic        density_violation_status, tx_line_short_status, tx_ones_missing_status;
  logic        signal_lost_irq, blue_alarm_irq, remote_alarm_onset_irq, remote_alarm_release_irq;
  logic        density_violation_irq, tx_line_change_irq, blue_alarm_send, remote_alarm_send;
  int          error_cnt = 0, compares = 0;
  assign {excess_zeros_read, density_violation_read, blue_alarm_irq_clr, signal_lost_irq_clr,
          remote_alarm_onset_irq_clr, remote_alarm_release_irq_clr, density_violation_irq_clr,
          tx_line_change_irq_clr} = ack;
  talm_monitor u_dut (.*);
  talm_line_model u_line (.*);
  always #50 clk_sys = ~clk_sys;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tx(input int n, input logic b, input logic o);
    repeat (n) begin
      @(posedge clk_sys) #1;
      {tx_bit_en, tx_bit, tx_overcurrent} = {1'b1, b, o};
    end
    @(posedge clk_sys) #1;
    tx_bit_en = '0;
  endtask
  // Reads and clears all; one pulse
  task automatic clear_all();
    @(posedge clk_sys) #1;
    ack = '1;
    @(posedge clk_sys) #1;
    ack = '0;
  endtask
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    tk(6);
    reset = '0;
    // Window counts frames from reset, so this goes first
    repeat (12) begin
      u_line.send(4, 1, 0);
      u_line.mark(0);
    end
    tk(3);
    `CHK("blue", 1'b1, blue_alarm_status)
    `CHK("blue_irq", 1'b1, blue_alarm_irq)
    clear_all();
    `CHK("blue_irq", 1'b0, blue_alarm_irq)
    `CHK("blue", 1'b1, blue_alarm_status)
    u_line.mark(1);
    repeat (12) begin
      u_line.send(1, 0, 0);
      u_line.send(3, 1, 0);
      u_line.mark(0);
    end
    tk(3);
    `CHK("blue", 1'b0, blue_alarm_status)
    `CHK("blue_irq", 1'b1, blue_alarm_irq)
    strict_blue_alarm_sel = '1;
    u_line.send(3, 0, 0);
    repeat (12) u_line.mark(0);
    tk(3);
    `CHK("blue", 1'b1, blue_alarm_status)
    u_line.send(8, 1, 0);
    clear_all();
    u_line.send(15, 0, 0);
    tk(3);
    `CHK("exz", 1'b0, excess_zeros_status)
    `CHK("lost", 1'b0, signal_lost_status)
    u_line.send(1, 0, 0);
    tk(3);
    `CHK("exz", 1'b1, excess_zeros_status)
    `CHK("pd", 1'b1, density_violation_status)
    `CHK("pd_irq", 1'b1, density_violation_irq)
    `CHK("lost", 1'b1, signal_lost_status)
    `CHK("lost_irq", 1'b1, signal_lost_irq)
    u_line.send(1, 1, 0);
    clear_all();
    `CHK("exz", 1'b0, excess_zeros_status)
    `CHK("pd", 1'b0, density_violation_status)
    u_line.send(8, 1, 0);
    tk(3);
    `CHK("lost", 1'b0, signal_lost_status)
    `CHK("lost_irq", 1'b1, signal_lost_irq)
    line_code = TALM_B8ZS;
    u_line.send(7, 0, 0);
    tk(3);
    `CHK("exz", 1'b0, excess_zeros_status)
    u_line.send(1, 0, 0);
    tk(3);
    `CHK("exz", 1'b1, excess_zeros_status)
    clear_all();
    u_line.send(254, 0, 1);
    tk(3);
    `CHK("ra", 1'b0, remote_alarm_status)
    u_line.send(1, 0, 1);
    tk(3);
    `CHK("ra", 1'b1, remote_alarm_status)
    `CHK("ra_on", 1'b1, remote_alarm_onset_irq)
    u_line.send(1, 1, 1);
    tk(3);
    `CHK("ra", 1'b0, remote_alarm_status)
    `CHK("ra_off", 1'b1, remote_alarm_release_irq)
    u_line.send(1, 1, 2);
    tk(3);
    `CHK("ra", 1'b1, remote_alarm_status)
    u_line.send(1, 0, 2);
    tk(3);
    `CHK("ra", 1'b0, remote_alarm_status)
    remote_alarm_mode_sel = '1;
    u_line.mark(0);
    u_line.send(24, 0, 1);
    u_line.mark(0);
    tk(3);
    `CHK("ra", 1'b1, remote_alarm_status)
    tx(31, 0, 0);
    tk(3);
    `CHK("ones", 1'b0, tx_ones_missing_status)
    tx(1, 0, 0);
    tk(3);
    `CHK("ones", 1'b1, tx_ones_missing_status)
    `CHK("tx_irq", 1'b1, tx_line_change_irq)
    clear_all();
    `CHK("tx_irq", 1'b0, tx_line_change_irq)
    tx(1, 1, 0);
    tk(3);
    `CHK("ones", 1'b0, tx_ones_missing_status)
    `CHK("tx_irq", 1'b1, tx_line_change_irq)
    tx(3, 1, 1);
    tk(3);
    `CHK("short", 1'b0, tx_line_short_status)
    tx(1, 1, 1);
    tk(3);
    `CHK("short", 1'b1, tx_line_short_status)
    tx(1, 1, 0);
    tk(3);
    `CHK("short", 1'b0, tx_line_short_status)
    {send_blue_alarm_en, send_remote_alarm_en} = 2'h3;
    tk(1);
    `CHK("ais_tx", 1'b1, blue_alarm_send)
    `CHK("ra_tx", 1'b1, remote_alarm_send)
    {send_blue_alarm_en, send_remote_alarm_en} = 2'h0;
    tk(1);
    `CHK("ais_tx", 1'b0, blue_alarm_send)
    conclude();
  end
  // Run takes under 700 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
